/* File: inc/mtaq_pkg.sv */
// Shared constants and types for the measurement trigger and acquisition sequencer
package mtaq_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_LEVEL   = 8'h08;
  localparam logic [7:0] OFS_HYST    = 8'h0C;
  localparam logic [7:0] OFS_COUNT   = 8'h10;
  localparam logic [7:0] OFS_POINTS  = 8'h14;
  localparam logic [7:0] OFS_OFFSET  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_ESR     = 8'h20;
  localparam logic [7:0] OFS_RESULT  = 8'h24;
  localparam logic [7:0] OFS_RDADDR  = 8'h28;

  // ==========================================================
  // Control fields
  localparam int CTRL_FUNC_LSB  = 0;
  localparam int CTRL_SRC_BIT   = 2;
  localparam int CTRL_SLOPE_LSB = 3;

  // Command bits (write one to issue)
  localparam int CMD_INIT  = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RST   = 2;
  localparam int CMD_IMM   = 3;
  localparam int CMD_TRG   = 4;
  localparam int CMD_OPC   = 5;

  // Status bits
  localparam int STAT_WTG   = 5;
  localparam int STAT_ERR   = 16;
  localparam int ESR_OPC    = 0;
  localparam int ESR_EXE    = 4;

  // ==========================================================
  // Limits and reset values
  localparam int          BUF_DEPTH      = 4096;
  localparam int          OFFSET_MIN     = -4095;
  localparam int          OFFSET_MAX     = 2000000000;
  localparam logic [31:0] COUNT_RST      = 32'h0000_0001;
  localparam logic [31:0] POINTS_RST     = 32'h0000_0400;
  localparam logic [31:0] RESP_OKAY      = 32'h0000_0000;
  localparam logic [1:0]  BRESP_OKAY     = 2'h0;
  localparam logic [1:0]  BRESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    MTAQ_FN_CURR = 2'h0,
    MTAQ_FN_VOLT = 2'h1,
    MTAQ_FN_AUX  = 2'h2
  } mtaq_func_t;

  typedef enum logic [1:0] {
    MTAQ_SL_POS    = 2'h0,
    MTAQ_SL_NEG    = 2'h1,
    MTAQ_SL_EITHER = 2'h2
  } mtaq_slope_t;

  typedef enum logic [3:0] {
    MTAQ_IDLE = 4'h1,
    MTAQ_ARM  = 4'h2,
    MTAQ_SKIP = 4'h4,
    MTAQ_CAPT = 4'h8
  } mtaq_state_t;

endpackage

/* File: rtl/mtaq_detector.sv */
// Level crossing detector with slope selection and hysteresis qualification
`timescale 1ns/1ps
module mtaq_detector
  import mtaq_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             enable,
  input  wire logic             sample_valid,
  input  wire logic signed [W-1:0] sample,
  input  wire logic signed [W-1:0] level,
  input  wire logic [W-1:0]     hyst,
  input  wire logic [1:0]       slope,
  output logic                  trig_pulse
);
  logic below_r;
  logic above_r;
  logic signed [W:0] lo_th;
  logic signed [W:0] hi_th;
  logic signed [W:0] s_ext;

  // One threshold, band around it
  assign lo_th = {level[W-1], level} - $signed({1'b0, hyst});
  assign hi_th = {level[W-1], level} + $signed({1'b0, hyst});
  assign s_ext = {sample[W-1], sample};

  // Armed flags: signal must first leave the band on the far side
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      below_r    <= 1'b0;
      above_r    <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      if (sample_valid) begin
        if (s_ext < lo_th) below_r <= 1'b1;
        if (s_ext > hi_th) above_r <= 1'b1;
        if (below_r && s_ext >= hi_th) begin
          below_r <= 1'b0;
          if (slope != MTAQ_SL_NEG) trig_pulse <= 1'b1;
        end
        if (above_r && s_ext <= lo_th) begin
          above_r <= 1'b0;
          if (slope != MTAQ_SL_POS) trig_pulse <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/mtaq_buffer.sv */
// Sample record storage, flip-flop array addressed by index
`timescale 1ns/1ps
module mtaq_buffer #(
  parameter int W     = 16,
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [W-1:0]       rdata
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if ((1 << AW) < DEPTH) $error("mtaq_buffer: AW too small for DEPTH");
  end

  always_ff @(posedge aclk) begin
    if (we) mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

/* File: rtl/mtaq_top.sv */
// Measurement trigger and acquisition sequencer with AXI4-Lite register port
// Contract
// - After reset the sequencer is idle, disabled, ignoring every trigger.
// - Abort or instrument reset returns the sequencer to idle from any state.
// - Initiate moves idle to initiated, where triggers are accepted.
// - After trigger and capture, return to idle unless count acquisitions remain.
// - No continuous re-arm; only the bounded trigger count repeats.
// - Source select picks bus triggers or internal detector triggers.
// - Internal trigger comes from the selected sensed signal.
// - One sensing function active at a time; host selects before triggering.
// - Immediate trigger works whatever source is selected.
// - With bus source, trigger command and group execute trigger both trigger.
// - One level threshold serves rising and falling crossings.
// - Slope selectable: rising, falling or either.
// - Crossing counts only after passing through the hysteresis band.
// - Result reads during acquisition are held until the last capture completes.
// - Pending completion request sets the complete bit when acquisition ends.
// - Count above one only for voltage and current; auxiliary input does one.
// - One initiate covers the count; each trigger appends samples to buffer.
// - Reject with error when count times points exceeds buffer capacity.
// - Trigger offset accepted only within its documented signed range.
// - Negative offset gives pre-trigger samples; positive skips samples after trigger.
// - Trigger before pre-trigger samples are collected is ignored.
// - Waiting-for-trigger flag at status bit 5 while initiated and waiting.
`timescale 1ns/1ps
module mtaq_top
  import mtaq_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = BUF_DEPTH,
  parameter int AW    = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Sample streams and bus trigger message
  input  wire logic          sample_tick,
  input  wire logic [W-1:0]  out_voltage_sample,
  input  wire logic [W-1:0]  out_current_sample,
  input  wire logic [W-1:0]  auxiliary_voltmeter_input,
  input  wire logic          group_execute_trigger,
  output logic               awaiting_trigger_flag,
  output logic               acquisition_busy
);

  initial begin
    if (DEPTH > BUF_DEPTH || (1 << AW) < DEPTH) $error("mtaq_top: bad DEPTH/AW");
  end

  // ==========================================================
  // Registers
  mtaq_state_t  state_r;
  logic [1:0]   func_r;
  logic         src_int_r;
  logic [1:0]   slope_r;
  logic [W-1:0] level_r;
  logic [W-1:0] hyst_r;
  logic [31:0]  count_r;
  logic [31:0]  points_r;
  logic signed [31:0] offset_r;
  logic         err_r;
  logic         esr_opc_r;
  logic         esr_exe_r;
  logic         opc_pend_r;
  logic [AW-1:0] rd_idx_r;

  logic [AW:0]  wptr_r;
  logic [AW:0]  rec_base_r;
  logic [31:0]  acq_left_r;
  logic [31:0]  pre_cnt_r;
  logic [31:0]  skip_r;
  logic [31:0]  post_r;

  // AXI handshake state
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        rd_pend_r;
  logic [7:0]  ar_addr_r;

  // ==========================================================
  // Helper functions
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic setup_ok(input logic [31:0] cnt, input logic [31:0] pts,
                                    input logic signed [31:0] ofs);
    logic [63:0] prod;
    prod = 64'(cnt) * 64'(pts);
    return (prod <= 64'(DEPTH)) && (pts != 32'h0) && (cnt != 32'h0)
           && (ofs >= OFFSET_MIN) && (ofs <= OFFSET_MAX)
           && (ofs >= 0 || 32'(-ofs) <= pts);
  endfunction

  // ==========================================================
  // Write decode
  logic        wr_fire;
  logic [31:0] cmd_w;
  logic        wr_known;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign cmd_w   = (wr_fire && aw_addr_r == OFS_CMD) ? w_data_r : 32'h0;
  always_comb begin
    case (aw_addr_r)
      OFS_CTRL, OFS_CMD, OFS_LEVEL, OFS_HYST, OFS_COUNT, OFS_POINTS, OFS_OFFSET,
      OFS_ESR, OFS_RDADDR: wr_known = 1'b1;
      default:             wr_known = 1'b0;
    endcase
  end

  logic go_idle;
  logic start_cmd;
  assign go_idle   = cmd_w[CMD_ABORT] || cmd_w[CMD_RST];
  assign start_cmd = cmd_w[CMD_INIT] && !go_idle;

  // ==========================================================
  // Sample selection and trigger sources
  logic [W-1:0] sample_sel;
  logic         det_trig;
  logic         bus_trig;
  logic         trig_any;
  always_comb begin
    case (func_r)
      MTAQ_FN_VOLT: sample_sel = out_voltage_sample;
      MTAQ_FN_AUX:  sample_sel = auxiliary_voltmeter_input;
      default:      sample_sel = out_current_sample;
    endcase
  end

  mtaq_detector #(.W(W)) u_det (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (state_r != MTAQ_IDLE),
    .sample_valid (sample_tick),
    .sample       ($signed(sample_sel)),
    .level        ($signed(level_r)),
    .hyst         (hyst_r),
    .slope        (slope_r),
    .trig_pulse   (det_trig)
  );

  // Immediate trigger ignores the source
  assign bus_trig = !src_int_r && (cmd_w[CMD_TRG] || group_execute_trigger);
  assign trig_any = cmd_w[CMD_IMM] || bus_trig || (src_int_r && det_trig);

  logic pre_ready;
  assign pre_ready = (offset_r >= 0) || (pre_cnt_r >= 32'(-offset_r));

  // ==========================================================
  // Sequencer
  logic last_acq;
  logic capt_done;
  assign last_acq  = (acq_left_r <= 32'h1);
  assign capt_done = (state_r == MTAQ_CAPT) && sample_tick && (post_r <= 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= MTAQ_IDLE;
    end else if (go_idle) begin
      state_r <= MTAQ_IDLE;
    end else begin
      case (state_r)
        MTAQ_IDLE: begin
          // Triggers here fall through unrecorded
          if (start_cmd && setup_ok(count_r, points_r, offset_r))
            state_r <= MTAQ_ARM;
        end
        MTAQ_ARM: begin
          if (trig_any && pre_ready) begin
            state_r <= (offset_r > 0) ? MTAQ_SKIP : MTAQ_CAPT;
          end
        end
        MTAQ_SKIP: begin
          if (sample_tick && skip_r <= 32'h1) state_r <= MTAQ_CAPT;
        end
        MTAQ_CAPT: begin
          if (capt_done) state_r <= last_acq ? MTAQ_IDLE : MTAQ_ARM;
        end
        default: state_r <= MTAQ_IDLE;
      endcase
    end
  end

  // Counters for record placement and timing
  logic sample_we;
  logic [AW:0] rec_len;
  assign rec_len   = (AW+1)'(points_r);
  assign sample_we = sample_tick && (state_r == MTAQ_ARM || state_r == MTAQ_CAPT);

  always_ff @(posedge aclk) begin
    if (!aresetn || go_idle) begin
      wptr_r     <= '0;
      rec_base_r <= '0;
      pre_cnt_r  <= 32'h0;
      skip_r     <= 32'h0;
      post_r     <= 32'h0;
      acq_left_r <= 32'h0;
    end else begin
      if (state_r == MTAQ_IDLE && start_cmd) begin
        wptr_r     <= '0;
        rec_base_r <= '0;
        pre_cnt_r  <= 32'h0;
        // Auxiliary input: one acquisition only
        acq_left_r <= (func_r == MTAQ_FN_AUX) ? 32'h1 : count_r;
      end
      if (state_r == MTAQ_ARM) begin
        // Pre-trigger ring within this record's slot
        if (sample_tick && offset_r < 0) begin
          wptr_r <= (wptr_r + 1'b1 == rec_base_r + (AW+1)'(-offset_r))
                    ? rec_base_r : wptr_r + 1'b1;
          if (pre_cnt_r < 32'(-offset_r)) pre_cnt_r <= pre_cnt_r + 32'h1;
        end
        if (trig_any && pre_ready) begin
          skip_r <= offset_r;
          post_r <= (offset_r < 0) ? points_r - 32'(-offset_r) : points_r;
          if (offset_r < 0) wptr_r <= rec_base_r + (AW+1)'(-offset_r);
        end
      end
      if (state_r == MTAQ_SKIP && sample_tick) skip_r <= skip_r - 32'h1;
      if (state_r == MTAQ_CAPT && sample_tick) begin
        wptr_r <= wptr_r + 1'b1;
        post_r <= post_r - 32'h1;
      end
      if (capt_done) begin
        // Next record appends
        acq_left_r <= acq_left_r - 32'h1;
        rec_base_r <= rec_base_r + rec_len;
        wptr_r     <= rec_base_r + rec_len;
        pre_cnt_r  <= 32'h0;
      end
    end
  end

  // Pre-trigger writes land in ring; rotation left to software read order
  logic [W-1:0] buf_rdata;
  mtaq_buffer #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_buf (
    .aclk  (aclk),
    .we    (sample_we && (state_r == MTAQ_CAPT || offset_r < 0)),
    .waddr (wptr_r[AW-1:0]),
    .wdata (sample_sel),
    .raddr (rd_idx_r),
    .rdata (buf_rdata)
  );

  // ==========================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_w[CMD_RST]) begin
      func_r    <= MTAQ_FN_CURR;
      src_int_r <= 1'b0;
      slope_r   <= MTAQ_SL_POS;
      level_r   <= '0;
      hyst_r    <= '0;
      count_r   <= COUNT_RST;
      points_r  <= POINTS_RST;
      offset_r  <= 32'sh0;
      rd_idx_r  <= '0;
    end else if (wr_fire) begin
      case (aw_addr_r)
        OFS_CTRL: begin
          func_r    <= w_data_r[CTRL_FUNC_LSB +: 2];
          src_int_r <= w_data_r[CTRL_SRC_BIT];
          slope_r   <= w_data_r[CTRL_SLOPE_LSB +: 2];
        end
        OFS_LEVEL:  level_r  <= W'(merge(32'(level_r), w_data_r, w_strb_r));
        OFS_HYST:   hyst_r   <= W'(merge(32'(hyst_r), w_data_r, w_strb_r));
        OFS_COUNT:  count_r  <= merge(count_r, w_data_r, w_strb_r);
        OFS_POINTS: points_r <= merge(points_r, w_data_r, w_strb_r);
        OFS_OFFSET: begin
          // Out-of-range offset refused
          if ($signed(w_data_r) >= OFFSET_MIN && $signed(w_data_r) <= OFFSET_MAX)
            offset_r <= w_data_r;
        end
        OFS_RDADDR: rd_idx_r <= AW'(w_data_r);
        default: ;
      endcase
    end
  end

  // Status: error, event status, completion request
  logic ofs_bad;
  assign ofs_bad = wr_fire && aw_addr_r == OFS_OFFSET &&
                   ($signed(w_data_r) < OFFSET_MIN || $signed(w_data_r) > OFFSET_MAX);
  logic setup_bad;
  assign setup_bad = state_r == MTAQ_IDLE && start_cmd && !setup_ok(count_r, points_r, offset_r);

  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_w[CMD_RST]) begin
      err_r      <= 1'b0;
      esr_opc_r  <= 1'b0;
      esr_exe_r  <= 1'b0;
      opc_pend_r <= 1'b0;
    end else begin
      // Set wins over clear on the same write
      if (wr_fire && aw_addr_r == OFS_ESR) begin
        esr_opc_r <= 1'b0;
        esr_exe_r <= 1'b0;
        err_r     <= 1'b0;
      end
      if (setup_bad || ofs_bad) begin
        err_r     <= 1'b1;
        esr_exe_r <= 1'b1;
      end
      if (cmd_w[CMD_OPC] && state_r != MTAQ_IDLE) opc_pend_r <= 1'b1;
      if (go_idle) opc_pend_r <= 1'b0;
      if (capt_done && last_acq && (opc_pend_r || cmd_w[CMD_OPC])) begin
        esr_opc_r  <= 1'b1;
        opc_pend_r <= 1'b0;
      end
      if (cmd_w[CMD_OPC] && state_r == MTAQ_IDLE && !start_cmd) esr_opc_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaiting_trigger_flag <= 1'b0;
      acquisition_busy      <= 1'b0;
    end else begin
      awaiting_trigger_flag <= (state_r == MTAQ_ARM);
      acquisition_busy      <= (state_r != MTAQ_IDLE);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= BRESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? BRESP_OKAY : BRESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel; result reads stall while busy
  logic [31:0] rd_word;
  logic        rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (ar_addr_r)
      OFS_CTRL:   rd_word = 32'({slope_r, src_int_r, func_r});
      OFS_LEVEL:  rd_word = 32'(level_r);
      OFS_HYST:   rd_word = 32'(hyst_r);
      OFS_COUNT:  rd_word = count_r;
      OFS_POINTS: rd_word = points_r;
      OFS_OFFSET: rd_word = offset_r;
      OFS_STATUS: rd_word = (32'(state_r == MTAQ_ARM) << STAT_WTG) |
                            (32'(err_r) << STAT_ERR);
      OFS_ESR:    rd_word = (32'(esr_opc_r) << ESR_OPC) | (32'(esr_exe_r) << ESR_EXE);
      OFS_RESULT: rd_word = 32'(buf_rdata);
      OFS_RDADDR: rd_word = 32'(rd_idx_r);
      default: begin
        rd_word  = RESP_OKAY;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_r     <= 1'b0;
      ar_addr_r     <= 8'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= BRESP_OKAY;
    end else begin
      s_axi_arready <= !rd_pend_r && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_r <= 1'b1;
        ar_addr_r <= {s_axi_araddr[7:2], 2'b00};
      end
      // Result reads held off while busy
      if (rd_pend_r && !(ar_addr_r == OFS_RESULT && state_r != MTAQ_IDLE)) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? BRESP_OKAY : BRESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/mtaq_top_assertions.sv */
// Port assertions for the acquisition sequencer
`timescale 1ns/1ps
module mtaq_top_assertions
  import mtaq_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        awaiting_trigger_flag,
  input logic        acquisition_busy
);
  // ========
  // Handshakes
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
  // Result reads stall while busy: no bound
  sequence ar_plain; s_axi_arvalid && s_axi_arready && s_axi_araddr != OFS_RESULT; endsequence
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("bvalid not held");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("rvalid not held");
  write_answer_a: assert property (aw_taken |-> ##[1:4] s_axi_bvalid) else $error("no bvalid");
  read_answer_a: assert property (ar_plain |-> ##[1:3] s_axi_rvalid) else $error("no rvalid");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
  // ========
  // Sequencer
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    !awaiting_trigger_flag && !acquisition_busy) else $error("not idle after reset");
  wait_busy_a: assert property (awaiting_trigger_flag |-> acquisition_busy)
    else $error("waiting while idle");
endmodule
bind mtaq_top mtaq_top_assertions u_chk (.*);

/* File: tb/mtaq_host_model.sv */
// Host controller model: AXI4-Lite master for register commands
`timescale 1ns/1ps
module mtaq_host_model (
  input  logic        aclk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ========
  // Released payloads show their inverse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`define CMP(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module testbench;
  import mtaq_pkg::*;
  typedef struct {string nm; logic [33:0] e, m;} mtaq_exp_t;
  localparam logic [33:0] M5 = 34'h20, M16 = 34'h10000, MW = 34'hFFFF;
  logic        aclk, aresetn, sample_tick, group_execute_trigger;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] out_voltage_sample, out_current_sample, auxiliary_voltmeter_input, va;
  logic        awaiting_trigger_flag, acquisition_busy;
  int          err_count, n_tests;
  mtaq_exp_t   q[$];
  mtaq_exp_t   x;
  mtaq_top DUT (.*);
  mtaq_host_model h (.*);
  // ========
  // Helpers
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) sample_tick <= ($urandom_range(3) == 0);
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
      x = q.pop_front();
      `CMP(x.nm, x.e, {s_axi_rresp, s_axi_rdata} & x.m)
    end
  task automatic chk(input logic [7:0] a, input string n, input logic [33:0] e, m);
    q.push_back('{n, e & m, m});
    h.rd(a);
  endtask
  task automatic cmd(input int b);
    h.wr(OFS_CMD, 32'h1 << b);
  endtask
  task automatic wait_for(input bit busy, input logic v);
    repeat (3000) if ((busy ? acquisition_busy : awaiting_trigger_flag) !== v) @(posedge aclk);
    `CMP("wait", v, busy ? acquisition_busy : awaiting_trigger_flag)
  endtask
  task automatic trig();
    @(posedge aclk) group_execute_trigger <= 1'b1;
    @(posedge aclk) group_execute_trigger <= 1'b0;
  endtask
  task automatic smp();
    out_voltage_sample <= 16'($urandom);
    out_current_sample <= 16'($urandom);
    auxiliary_voltmeter_input <= 16'($urandom);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  // ========
  // Tests
  initial begin
    void'($urandom(86984));
    {aresetn, group_execute_trigger, out_voltage_sample, out_current_sample} = '0;
    auxiliary_voltmeter_input = 16'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(OFS_COUNT, "count", COUNT_RST, '1);
    chk(OFS_STATUS, "status", 34'h0, M5);
    chk(8'h40, "unmapped", {BRESP_SLVERR, 32'h0}, '1);
    trig();
    cmd(CMD_IMM);
    h.wr(OFS_POINTS, 32'h4);
    h.wr(OFS_CTRL, 32'(MTAQ_FN_VOLT));
    cmd(CMD_INIT);
    chk(OFS_STATUS, "armed", M5, M5);
    cmd(CMD_ABORT);
    chk(OFS_STATUS, "aborted", 34'h0, M5);
    $display("test idle done");
    h.wr(OFS_COUNT, 32'h2);
    smp();
    cmd(CMD_INIT);
    trig();
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    va = out_voltage_sample;
    smp();
    cmd(CMD_TRG);
    wait_for(1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      h.wr(OFS_RDADDR, 32'(i));
      chk(OFS_RESULT, "record", (i < 4) ? va : out_voltage_sample, MW);
    end
    h.wr(OFS_CTRL, 32'(MTAQ_FN_AUX));
    smp();
    cmd(CMD_INIT);
    trig();
    wait_for(1, 1'b0);
    `CMP("aux single", 1'b0, acquisition_busy)
    h.wr(OFS_RDADDR, 32'h0);
    chk(OFS_RESULT, "aux record", auxiliary_voltmeter_input, MW);
    $display("test bus trigger done");
    h.wr(OFS_COUNT, 32'h1);
    h.wr(OFS_LEVEL, 32'h7FFF);
    h.wr(OFS_HYST, 32'h0);
    h.wr(OFS_CTRL, 32'h1 << CTRL_SRC_BIT);
    h.wr(OFS_ESR, 32'h0);
    cmd(CMD_INIT);
    cmd(CMD_OPC);
    trig();
    chk(OFS_ESR, "opc early", 34'h0, 34'h1);
    chk(OFS_STATUS, "bus ignored", M5, M5);
    fork
      chk(OFS_RESULT, "held", out_current_sample, MW);
      cmd(CMD_IMM);
    join
    wait_for(1, 1'b0);
    chk(OFS_ESR, "opc late", 34'h1, 34'h1);
    h.wr(OFS_LEVEL, 32'h0);
    h.wr(OFS_HYST, 32'h10);
    out_current_sample <= 16'hFF00;
    cmd(CMD_INIT);
    repeat (20) @(posedge aclk);
    out_current_sample <= 16'h0100;
    wait_for(1, 1'b0);
    $display("test internal done");
    h.wr(OFS_POINTS, 32'h400);
    h.wr(OFS_COUNT, 32'h4);
    cmd(CMD_INIT);
    chk(OFS_STATUS, "fits", M5, M5 | M16);
    cmd(CMD_ABORT);
    h.wr(OFS_COUNT, 32'h5);
    cmd(CMD_INIT);
    chk(OFS_STATUS, "too big", M16, M5 | M16);
    cmd(CMD_RST);
    h.wr(OFS_OFFSET, 32'hFFFF_F001);
    chk(OFS_STATUS, "offset ok", 34'h0, M16);
    h.wr(OFS_OFFSET, 32'hFFFF_F000);
    chk(OFS_STATUS, "offset low", M16, M16);
    $display("test limits done");
    give_verdict();
  end
endmodule
